// ### rtl/qfe_front_end.sv
/*
 * QAM mapper, input scaler and SRRC interpolator for NUM_CH lanes that share
 * one set of controls, with an input FIFO and a small register port.
 * Assumes the word source and register writer run on ref_clk.
 */
`timescale 1ns/100ps
module qfe_front_end #(
	parameter int NUM_CH = 4,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [qfe_pkg::REG_W-1:0] regAddr,
	input wire logic [qfe_pkg::REG_W-1:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [qfe_pkg::REG_W-1:0] regRdData,
	input wire logic inValid,
	output logic inReady,
	input wire logic [NUM_CH*qfe_pkg::WORD_W-1:0] inWordI,
	input wire logic [NUM_CH*qfe_pkg::WORD_W-1:0] inWordQ,
	output logic outValid,
	input wire logic outReady,
	output logic [NUM_CH*qfe_pkg::SAMP_W-1:0] outI,
	output logic [NUM_CH*qfe_pkg::SAMP_W-1:0] outQ
);
	import qfe_pkg::*;
	localparam int FW = 2 * NUM_CH * WORD_W;
	localparam int BW = NUM_CH * SAMP_W;
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	// ==========================================================
	// constellation helpers
	// odd axis level from a b-bit code: top bit is the sign, rest the magnitude
	function automatic int oddLvl(input logic [3:0] c, input int b);
		int m;
		m = int'(c) % (1 << (b - 1));
		if (((int'(c) >> (b - 1)) & 1) == 1) begin
			return 2 * m + 1;
		end
		return -(2 * m + 1);
	endfunction

	// cross modes fold the outer rows of a rectangle into side columns
	function automatic logic [2*SYM_W-1:0] mapSym(input logic [2:0] mode,
			input logic [WORD_W-1:0] w);
		int i;
		int q;
		int s;
		int t;
		i = 0;
		q = 0;
		s = 1;
		t = 0;
		case (mode)
			MODE_D64, MODE_C64: begin
				i = LVL64[w[5:3]];
				q = LVL64[w[2:0]];
			end
			MODE_D256, MODE_C256: begin
				i = oddLvl(w[7:4], 4);
				q = oddLvl(w[3:0], 4);
			end
			MODE_C16: begin
				i = oddLvl({2'h0, w[3:2]}, 2);
				q = oddLvl({2'h0, w[1:0]}, 2);
				s = 5;
			end
			MODE_C32: begin
				i = oddLvl({2'h0, w[4:3]}, 2);
				q = oddLvl({1'h0, w[2:0]}, 3);
				s = 3;
				if (q == 7 || q == -7) begin
					t = i;
					i = (q > 0) ? 5 : -5;
					q = t;
				end
			end
			MODE_C128: begin
				i = oddLvl({1'h0, w[6:4]}, 3);
				q = oddLvl(w[3:0], 4);
				if (q > 11 || q < -11) begin
					t = i;
					i = (q == 13) ? 9 : (q == 15) ? 11 : (q == -13) ? -9 : -11;
					q = t;
				end
			end
			default: begin
				i = 0;
				q = 0;
			end
		endcase
		return {SYM_W'(i * s), SYM_W'(q * s)};
	endfunction

	// gain/32 with round to nearest and clip to the 16-bit range
	function automatic logic [SAMP_W-1:0] scaleWord(input logic [WORD_W-1:0] w,
			input logic [WORD_W-1:0] g);
		logic signed [24:0] p;
		logic signed [24:0] r;
		p = 25'($signed({w, {(SAMP_W - WORD_W){1'b0}}})) * 25'($signed({1'b0, g}));
		r = (p + GAIN_RND) >>> GAIN_SHIFT;
		if (r > LIM_POS) begin
			return SAT_POS;
		end
		if (r < LIM_NEG) begin
			return SAT_NEG;
		end
		return r[SAMP_W-1:0];
	endfunction

	// ==========================================================
	// registers
	logic [REG_W-1:0] dpCtrl_q, dpCtrl_d, mapCfg_q, mapCfg_d;
	logic [REG_W-1:0] gain_q, gain_d, rdData_q, rdData_d;
	logic mapBypass, srrcBypass;
	logic [2:0] mode;
	logic [1:0] alpha;
	logic [REG_W-1:0] status;

	// datapath
	logic fifoValid, fifoReady, fifoPop, fifoWrRdy, allRdy, srrcIn;
	logic [FW-1:0] fifoData;
	logic [LW-1:0] fifoLevel;
	logic [NUM_CH-1:0] srrcInRdy, srrcOutVld;
	logic [BW-1:0] srrcI, srrcQ, bypI, bypQ;
	logic bypValid_q, bypValid_d;
	logic [BW-1:0] bypI_q, bypI_d, bypQ_q, bypQ_d;

	// shared controls for every lane
	assign mapBypass = dpCtrl_q[MAP_BYP_BIT];
	assign srrcBypass = dpCtrl_q[SRRC_BYP_BIT];
	assign mode = mapCfg_q[MODE_LSB +: 3];
	assign alpha = mapCfg_q[ALPHA_LSB +: 2];
	assign status = {4'(fifoLevel), (mode == MODE_NONE), outValid, !fifoWrRdy, fifoValid};
	assign regRdData = rdData_q;

	// register writes and registered reads; unmapped reads return zero
	always_comb begin
		dpCtrl_d = dpCtrl_q;
		mapCfg_d = mapCfg_q;
		gain_d = gain_q;
		rdData_d = rdData_q;
		if (regWrEn) begin
			case (regAddr)
				REG_DP_CTRL: dpCtrl_d = regWrData;
				REG_MAP_CFG: mapCfg_d = regWrData;
				REG_IN_GAIN: gain_d = regWrData;
				default: dpCtrl_d = dpCtrl_q;
			endcase
		end
		if (regRdEn) begin
			case (regAddr)
				REG_DP_CTRL: rdData_d = dpCtrl_q;
				REG_MAP_CFG: rdData_d = mapCfg_q;
				REG_IN_GAIN: rdData_d = gain_q;
				REG_STATUS: rdData_d = status;
				default: rdData_d = RD_RST;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dpCtrl_q <= DP_CTRL_RST;
			mapCfg_q <= MAP_CFG_RST;
			gain_q <= IN_GAIN_RST;
			rdData_q <= RD_RST;
		end else begin
			dpCtrl_q <= dpCtrl_d;
			mapCfg_q <= mapCfg_d;
			gain_q <= gain_d;
			rdData_q <= rdData_d;
		end
	end

	// ==========================================================
	// input FIFO: its ready is the source's back-pressure
	qfe_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.wrValid(inValid),
		.wrReady(fifoWrRdy),
		.wrData({inWordQ, inWordI}),
		.rdValid(fifoValid),
		.rdReady(fifoReady),
		.rdData(fifoData),
		.level(fifoLevel)
	);
	assign inReady = fifoWrRdy;

	// ==========================================================
	// per lane mapper, scaler and filter
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		logic [WORD_W-1:0] wI, wQ;
		logic [2*SYM_W-1:0] sym;
		logic [SAMP_W-1:0] sclI, sclQ;
		logic [SYM_W-1:0] fI, fQ;
		assign wI = fifoData[ch*WORD_W +: WORD_W];
		assign wQ = fifoData[(NUM_CH+ch)*WORD_W +: WORD_W];
		assign sym = mapSym(mode, wI);
		assign sclI = scaleWord(wI, gain_q);
		assign sclQ = scaleWord(wQ, gain_q);
		// five top bits feed the filter when the mapper is out of the path
		assign fI = mapBypass ? sclI[SAMP_W-1 -: SYM_W] : sym[2*SYM_W-1 -: SYM_W];
		assign fQ = mapBypass ? sclQ[SAMP_W-1 -: SYM_W] : sym[SYM_W-1:0];
		// scaler result is used only with the mapper bypassed
		assign bypI[ch*SAMP_W +: SAMP_W] = mapBypass ? sclI :
			{sym[2*SYM_W-1 -: SYM_W], {(SAMP_W - SYM_W){1'b0}}};
		assign bypQ[ch*SAMP_W +: SAMP_W] = mapBypass ? sclQ :
			{sym[SYM_W-1:0], {(SAMP_W - SYM_W){1'b0}}};
		qfe_srrc #(
			.IN_W(SYM_W),
			.OUT_W(SAMP_W)
		) u_srrc (
			.ref_clk(ref_clk),
			.nrst(nrst),
			.alphaSel(alpha),
			.inValid(srrcIn),
			.inReady(srrcInRdy[ch]),
			.inI(fI),
			.inQ(fQ),
			.outValid(srrcOutVld[ch]),
			.outReady(outReady && !srrcBypass),
			.outI(srrcI[ch*SAMP_W +: SAMP_W]),
			.outQ(srrcQ[ch*SAMP_W +: SAMP_W])
		);
	end

	// ==========================================================
	// flow: lanes move in lockstep, a word is offered only when all are free
	assign allRdy = &srrcInRdy;
	assign srrcIn = fifoValid && allRdy && !srrcBypass;
	assign fifoReady = srrcBypass ? (!bypValid_q || outReady) : allRdy;
	assign fifoPop = fifoValid && fifoReady;
	assign outValid = srrcBypass ? bypValid_q : srrcOutVld[0];
	assign outI = srrcBypass ? bypI_q : srrcI;
	assign outQ = srrcBypass ? bypQ_q : srrcQ;

	// bypass stage: a held sample is dropped if the bypass is switched off
	always_comb begin
		bypValid_d = bypValid_q;
		bypI_d = bypI_q;
		bypQ_d = bypQ_q;
		if (srrcBypass && fifoPop) begin
			bypValid_d = 1'b1;
			bypI_d = bypI;
			bypQ_d = bypQ;
		end else if (outReady || !srrcBypass) begin
			bypValid_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bypValid_q <= 1'b0;
			bypI_q <= '0;
			bypQ_q <= '0;
		end else begin
			bypValid_q <= bypValid_d;
			bypI_q <= bypI_d;
			bypQ_q <= bypQ_d;
		end
	end

	// ==========================================================
	// checks
	unusedMode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mode == MODE_NONE) |-> (g_ch[0].sym == 10'h000))
		else $error("unused mode produced a symbol");
	mapExample_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mode == MODE_D64 && g_ch[0].wI[5:0] == 6'h1D) |-> (g_ch[0].sym == {5'h06, 5'h16}))
		else $error("64-QAM example point mismatch");
	mapCorner_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mode == MODE_D64 && g_ch[0].wI[5:0] == 6'h3F) |-> (g_ch[0].sym == {5'h0E, 5'h0E}))
		else $error("all ones is not the upper right corner");
	ignoreUpper_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mode == MODE_C16) |-> (g_ch[0].sym == mapSym(MODE_C16, {4'h0, g_ch[0].wI[3:0]})))
		else $error("16-QAM used upper input bits");
	range128_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mode == MODE_C128) |-> ($signed(g_ch[0].sym[9:5]) <= 11 &&
		$signed(g_ch[0].sym[9:5]) >= -11 && $signed(g_ch[0].sym[4:0]) <= 11 &&
		$signed(g_ch[0].sym[4:0]) >= -11))
		else $error("128-QAM coordinate out of range");
	scalerOff_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!mapBypass && srrcBypass && fifoPop) |=> (outValid && outI[SAMP_W-SYM_W-1:0] == '0))
		else $error("scaler touched mapped data");
	satPos_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(gain_q == 8'hFF && g_ch[0].wI == 8'h7F) |-> (g_ch[0].sclI == SAT_POS))
		else $error("positive overflow not clipped");
	unityGain_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(gain_q == IN_GAIN_RST) |-> (g_ch[0].sclI == {g_ch[0].wI, 8'h00}))
		else $error("gain 0x20 is not unity");
	bypassPass_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(srrcBypass && fifoPop) |=> (outValid && outI == $past(bypI)))
		else $error("filter bypass altered data");
	lockstep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!srrcBypass |-> (srrcInRdy == '0 || srrcInRdy == '1))
		else $error("lanes fell out of step");
endmodule : qfe_front_end

// ### rtl/qfe_pkg.sv
/*
 * Shared constants for the QAM mapper / SRRC front end: register map,
 * field positions, reset values, mapping mode codes and filter taps.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package qfe_pkg;
	// ==========================================================
	// register map and reset values
	localparam int REG_W = 8;
	localparam logic [7:0] REG_DP_CTRL = 8'h06;
	localparam logic [7:0] REG_MAP_CFG = 8'h07;
	localparam logic [7:0] REG_IN_GAIN = 8'h09;
	localparam logic [7:0] REG_STATUS = 8'h44;
	localparam logic [7:0] DP_CTRL_RST = 8'h00;
	localparam logic [7:0] MAP_CFG_RST = 8'h00;
	localparam logic [7:0] IN_GAIN_RST = 8'h20;
	localparam logic [7:0] RD_RST = 8'h00;

	// ==========================================================
	// field positions
	localparam int MODE_LSB = 0;
	localparam int ALPHA_LSB = 4;
	localparam int SRRC_BYP_BIT = 6;
	localparam int MAP_BYP_BIT = 7;

	// ==========================================================
	// mapping mode codes
	localparam logic [2:0] MODE_D64 = 3'h0;
	localparam logic [2:0] MODE_D256 = 3'h1;
	localparam logic [2:0] MODE_C16 = 3'h2;
	localparam logic [2:0] MODE_C32 = 3'h3;
	localparam logic [2:0] MODE_C64 = 3'h4;
	localparam logic [2:0] MODE_C128 = 3'h5;
	localparam logic [2:0] MODE_C256 = 3'h6;
	localparam logic [2:0] MODE_NONE = 3'h7;

	// ==========================================================
	// datapath widths and scaler arithmetic
	localparam int WORD_W = 8;
	localparam int SYM_W = 5;
	localparam int SAMP_W = 16;
	localparam int GAIN_SHIFT = 5;
	localparam logic signed [24:0] GAIN_RND = 25'sh0000010;
	localparam logic signed [24:0] LIM_POS = 25'sh0007FFF;
	localparam logic signed [24:0] LIM_NEG = 25'sh1FF8000;
	localparam logic [15:0] SAT_POS = 16'h7FFF;
	localparam logic [15:0] SAT_NEG = 16'h8000;
	// 64-QAM axis level per 3-bit code
	localparam int LVL64 [8] = '{-2, -6, 2, 6, -14, -10, 10, 14};

	// ==========================================================
	// srrc taps: first half of a symmetric 16-tap filter, one row per roll-off
	localparam int SRRC_HALF_N = 8;
	localparam int SRRC_OUT_SHIFT = 2;
	localparam int SRRC_HALF [4][8] = '{
		'{-4, 6, 10, -14, -24, 28, 118, 230},
		'{-4, 5, 10, -13, -24, 29, 118, 229},
		'{-3, 5, 9, -12, -23, 30, 119, 228},
		'{-2, 4, 8, -10, -21, 32, 120, 226}
	};

	typedef enum logic [1:0] {SR_EMPTY, SR_PH0, SR_PH1} qfe_srrc_st_t;
endpackage : qfe_pkg

// ### rtl/qfe_fifo.sv
/*
 * Word FIFO with valid/ready on both sides, in front of the datapath.
 * Assumes one clock for writer and reader; data out is read from the array.
 */
`timescale 1ns/100ps
module qfe_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [WIDTH-1:0] wrData,
	output logic rdValid,
	input wire logic rdReady,
	output logic [WIDTH-1:0] rdData,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	import qfe_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [LW-1:0] cnt_q, cnt_d;
	logic push, pop;

	// ==========================================================
	// handshake: full and empty come straight from the count
	assign wrReady = (cnt_q != LW'(DEPTH));
	assign rdValid = (cnt_q != '0);
	assign rdData = mem_q[rdPtr_q];
	assign level = cnt_q;
	assign push = wrValid && wrReady;
	assign pop = rdValid && rdReady;

	// next pointers, count and array contents
	always_comb begin
		mem_d = mem_q;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wrPtr_q] = wrData;
			wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
		end
		if (pop) begin
			rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int k = 0; k < DEPTH; k++) begin
				mem_q[k] <= '0;
			end
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			cnt_q <= cnt_d;
		end
	end

	fullStall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(cnt_q == LW'(DEPTH)) |-> (!wrReady ##1 cnt_q >= LW'(DEPTH - 1)))
		else $error("fifo accepted a word while full");
endmodule : qfe_fifo

// ### rtl/qfe_srrc.sv
/*
 * 2x interpolating square-root-raised-cosine filter for one complex lane.
 * Assumes 5-bit signed I/Q in; the downstream drains two samples per input.
 */
`timescale 1ns/100ps
module qfe_srrc #(
	parameter int IN_W = 5,
	parameter int OUT_W = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [1:0] alphaSel,
	input wire logic inValid,
	output logic inReady,
	input wire logic [IN_W-1:0] inI,
	input wire logic [IN_W-1:0] inQ,
	output logic outValid,
	input wire logic outReady,
	output logic [OUT_W-1:0] outI,
	output logic [OUT_W-1:0] outQ
);
	import qfe_pkg::*;
	localparam int N = SRRC_HALF_N;

	qfe_srrc_st_t st_q, st_d;
	logic signed [IN_W-1:0] dI_q [N];
	logic signed [IN_W-1:0] dI_d [N];
	logic signed [IN_W-1:0] dQ_q [N];
	logic signed [IN_W-1:0] dQ_d [N];
	logic [OUT_W-1:0] oI_q, oI_d, oQ_q, oQ_d;

	// one polyphase branch: phase 0 uses even taps, phase 1 odd taps
	function automatic logic [OUT_W-1:0] fir(input logic signed [IN_W-1:0] d [N],
			input int ph, input logic [1:0] a);
		int acc;
		int tap;
		int c;
		acc = 0;
		for (int k = 0; k < N; k++) begin
			tap = 2 * k + ph;
			c = (tap < N) ? SRRC_HALF[a][tap] : SRRC_HALF[a][2 * N - 1 - tap];
			acc = acc + int'(d[k]) * c;
		end
		return OUT_W'(acc <<< SRRC_OUT_SHIFT);
	endfunction

	// ==========================================================
	// sample in, then two output phases; no overlap keeps the taps stable
	assign inReady = (st_q == SR_EMPTY);
	assign outValid = (st_q != SR_EMPTY);
	assign outI = oI_q;
	assign outQ = oQ_q;

	always_comb begin
		st_d = st_q;
		dI_d = dI_q;
		dQ_d = dQ_q;
		oI_d = oI_q;
		oQ_d = oQ_q;
		case (st_q)
			SR_EMPTY: begin
				if (inValid) begin
					dI_d[0] = inI;
					dQ_d[0] = inQ;
					for (int k = 1; k < N; k++) begin
						dI_d[k] = dI_q[k-1];
						dQ_d[k] = dQ_q[k-1];
					end
					oI_d = fir(dI_d, 0, alphaSel);
					oQ_d = fir(dQ_d, 0, alphaSel);
					st_d = SR_PH0;
				end
			end
			SR_PH0: begin
				if (outReady) begin
					oI_d = fir(dI_q, 1, alphaSel);
					oQ_d = fir(dQ_q, 1, alphaSel);
					st_d = SR_PH1;
				end
			end
			SR_PH1: begin
				if (outReady) begin
					st_d = SR_EMPTY;
				end
			end
			default: begin
				st_d = SR_EMPTY;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= SR_EMPTY;
			for (int k = 0; k < N; k++) begin
				dI_q[k] <= '0;
				dQ_q[k] <= '0;
			end
			oI_q <= '0;
			oQ_q <= '0;
		end else begin
			st_q <= st_d;
			dI_q <= dI_d;
			dQ_q <= dQ_d;
			oI_q <= oI_d;
			oQ_q <= oQ_d;
		end
	end

	twoOutputs_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(inValid && inReady) |=> (outValid && !inReady) ##0 (st_q == SR_PH0))
		else $error("srrc did not start two output phases");
	secondPhase_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st_q == SR_PH0 && outReady) |=> (outValid && st_q == SR_PH1))
		else $error("srrc skipped its second output");
endmodule : qfe_srrc

// ### test/qfe_host_src.sv
/*
 * Host word source: queued four-lane I/Q words on valid/ready, with an
 * optional idle gap after each accepted word.
 * Assumes ref_clk and nrst are shared with the front end.
 */
`timescale 1ns/100ps
module qfe_host_src (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic inReady,
	output logic inValid,
	output logic [31:0] inWordI,
	output logic [31:0] inWordQ
);
	logic [31:0] qI[$];
	logic [31:0] qQ[$];
	int gap = 0;
	int cnt = 0;
	int nTaken = 0;

	// ==========================================================
	// queue feeding from the bench
	task automatic push(input logic [31:0] wI, input logic [31:0] wQ);
		qI.push_back(wI);
		qQ.push_back(wQ);
	endtask : push

	// ==========================================================
	// word stands until taken; idle lines invert their data each cycle, so a stale word shows only on alternate idle cycles
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			inValid <= 1'b0;
			inWordI <= 32'h0;
			inWordQ <= 32'h0;
		end else begin
			if (inValid && inReady) begin
				void'(qI.pop_front());
				void'(qQ.pop_front());
				nTaken++;
				cnt = gap;
			end else if (cnt > 0) begin
				cnt--;
			end
			if (qI.size() > 0 && cnt == 0) begin
				inValid <= 1'b1;
				inWordI <= qI[0];
				inWordQ <= qQ[0];
			end else begin
				inValid <= 1'b0;
				inWordI <= ~inWordI;
				inWordQ <= ~inWordQ;
			end
		end
	end
endmodule : qfe_host_src

// ### test/testbench.sv
/*
 * Self-checking bench for the front end: register tasks, mapper table,
 * scaler gains, SRRC rate per roll-off, FIFO fill and drain.
 * Assumes the host source model and the design package.
 */
`timescale 1ns/100ps
module testbench;
	import qfe_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
	logic regWrEn = 1'b0, regRdEn = 1'b0, outReady = 1'b0;
	logic inValid, inReady, outValid;
	logic [31:0] inWordI, inWordQ;
	logic [63:0] outI, outQ;
	logic [63:0] gotI[$];
	logic [63:0] gotQ[$];
	int n_fail = 0, compares = 0, sinkMode = 0;
	// mode, word, I level, Q level, exact (0: range only)
	int tab[11][5] = '{'{0, 'h1D, 6, -10, 1}, '{0, 'hDD, 6, -10, 1}, '{0, 'h3F, 14, 14, 1},
		'{4, 'hC0, -2, -2, 1}, '{1, 'hFF, 15, 15, 1}, '{6, 'h00, -1, -1, 1},
		'{2, 'hF0, -5, -5, 1}, '{3, 'hE0, -3, -3, 1}, '{5, 'h80, 0, 0, 0},
		'{5, 'h7F, 0, 0, 0}, '{7, 'hFF, 0, 0, 1}};
	logic [7:0] gains[5] = '{8'h20, 8'h21, 8'h00, 8'h40, 8'hFF};

	always #5 ref_clk = ~ref_clk;

	qfe_front_end #(.NUM_CH(4), .FIFO_DEPTH(8)) dut (.ref_clk(ref_clk), .nrst(nrst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .inValid(inValid), .inReady(inReady), .inWordI(inWordI),
		.inWordQ(inWordQ), .outValid(outValid), .outReady(outReady), .outI(outI),
		.outQ(outQ));
	qfe_host_src src (.ref_clk(ref_clk), .nrst(nrst), .inReady(inReady), .inValid(inValid),
		.inWordI(inWordI), .inWordQ(inWordQ));

	// ==========================================================
	// sink: collects samples; mode 2 stalls every other cycle
	always @(posedge ref_clk) begin
		if (outValid === 1'b1 && outReady) begin
			gotI.push_back(outI);
			gotQ.push_back(outQ);
		end
		outReady <= (sinkMode == 1) || (sinkMode == 2 && !outReady);
	end

	// ==========================================================
	// checks, register access and expectations
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1 chk({8'h00, regRdData}, {8'h00, exp});
	endtask : rd

	// bounded wait for n samples; a shortfall counts as a mismatch
	task automatic collect(input int n);
		int t = 0;
		while (gotI.size() < n && t < 400) begin
			@(posedge ref_clk);
			t++;
		end
		chk(16'(gotI.size() >= n), 16'h1);
	endtask : collect

	task automatic clr();
		gotI.delete();
		gotQ.delete();
	endtask : clr

	// symbol sits in the top five bits, zeros below
	function automatic logic [15:0] sym(input int v);
		return {v[4:0], 11'h000};
	endfunction : sym

	// word taken as the top byte of 16 bits, times gain over 32, rounded, clipped
	function automatic logic [15:0] scl(input logic [7:0] w, input logic [7:0] g);
		int p;
		p = (int'($signed(w)) * 256 * int'(g) + 16) >>> 5;
		if (p > 32767) return 16'h7FFF;
		if (p < -32768) return 16'h8000;
		return p[15:0];
	endfunction : scl

	// ==========================================================
	// closing and watchdog
	task automatic conclude();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		#200000;
		n_fail++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		logic [15:0] v;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		sinkMode = 1;
		chk({15'h0, inReady}, 16'h1);
		chk({15'h0, outValid}, 16'h0);
		rd(REG_STATUS, 8'h00);
		rd(REG_DP_CTRL, 8'h00);
		rd(REG_MAP_CFG, 8'h00);
		rd(REG_IN_GAIN, 8'h20);
		wr(8'h03, 8'h5A);
		rd(8'h03, 8'h00);
		wr(REG_MAP_CFG, 8'h35);
		rd(REG_MAP_CFG, 8'h35);
		// scaler path: mapper and filter both bypassed
		wr(REG_DP_CTRL, 8'hC0);
		foreach (gains[g]) begin
			wr(REG_IN_GAIN, gains[g]);
			rd(REG_IN_GAIN, gains[g]);
			// lane 0 carries 0x7F so the top gain drives it into positive clipping
			src.push(32'h01B0507F, 32'hC312FF80);
			collect(1);
			for (int k = 0; k < 4; k++) begin
				chk(gotI[0][16*k+:16], scl(8'(32'h01B0507F >> (8 * k)), gains[g]));
				chk(gotQ[0][16*k+:16], scl(8'(32'hC312FF80 >> (8 * k)), gains[g]));
			end
			clr();
		end
		// mapper with filter bypassed; gain left at 0xFF must not touch symbols
		wr(REG_DP_CTRL, 8'h40);
		foreach (tab[e]) begin
			wr(REG_MAP_CFG, 8'(tab[e][0]));
			src.push({4{8'(tab[e][1])}}, 32'hA5A5A5A5);
			collect(1);
			for (int k = 0; k < 4; k++) begin
				v = gotI[0][16*k+:16];
				if (tab[e][4] == 1) begin
					chk(v, sym(tab[e][2]));
					chk(gotQ[0][16*k+:16], sym(tab[e][3]));
				end else begin
					chk(16'($signed(v[15:11]) <= 11 && $signed(v[15:11]) >= -11), 16'h1);
					chk({5'h00, v[10:0]}, 16'h0);
				end
			end
			clr();
		end
		// filter on, slow host, stalling sink; one pass for each of the four roll-offs
		wr(REG_DP_CTRL, 8'h00);
		src.gap = 2;
		sinkMode = 2;
		for (int a = 0; a < 4; a++) begin
			wr(REG_MAP_CFG, 8'(a * 16));
			repeat (3) src.push(32'h3F1D003F, 32'h0);
			collect(6);
			// empty history on the first pass: phase 0 is the symbol times the first tap
			if (a == 0) chk(gotI[0][15:0], 16'(14 * SRRC_HALF[0][0] <<< SRRC_OUT_SHIFT));
			repeat (10) @(posedge ref_clk);
			chk(16'(gotI.size()), 16'h6);
			clr();
		end
		wr(REG_MAP_CFG, 8'h07);
		repeat (12) src.push(32'h3F1D003F, 32'h0);
		collect(24);
		chk(gotI[23][15:0] | gotI[23][63:48] | gotQ[23][31:16], 16'h0);
		clr();
		// buffer: fill with sink stopped until refused, then drain with stalls
		src.gap = 0;
		sinkMode = 0;
		wr(REG_DP_CTRL, 8'hC0);
		wr(REG_IN_GAIN, 8'h20);
		for (int i = 0; i < 12; i++) src.push({4{8'(i * 16 + 3)}}, 32'h0);
		repeat (25) @(posedge ref_clk);
		#1 chk({15'h0, inReady}, 16'h0);
		chk(16'(src.nTaken >= 8), 16'h1);
		// status is read only: level 8, unused mode, output held, full, not empty
		wr(REG_STATUS, 8'h00);
		rd(REG_STATUS, 8'h8F);
		sinkMode = 2;
		collect(12);
		for (int i = 0; i < 12; i++) chk(gotI[i][31:16], scl(8'(i * 16 + 3), 8'h20));
		conclude();
	end
endmodule : testbench
